// ==== inc/pcg_regs.svh ====
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
// Register byte offsets
`define PCG_OFF_SYS_CLK   8'h00
`define PCG_OFF_PLL_CTRL  8'h04
`define PCG_OFF_STBY      8'h08
`define PCG_OFF_MOD_STOP  8'h0c
`define PCG_OFF_PWR       8'h10
`define PCG_OFF_STATUS    8'h14
// Reset values
`define PCG_RST_SYS_CLK   8'h00
`define PCG_RST_PLL_CTRL  8'h00
`define PCG_RST_STBY      8'h40
`define PCG_RST_MOD_STOP  8'h00
`define PCG_RST_PWR       8'h00
// Writable bits; the rest read as zero
`define PCG_WM_SYS_CLK    8'hcf
`define PCG_WM_PLL_CTRL   8'h0b
`define PCG_WM_STBY       8'hcf
`define PCG_WM_PWR        8'h01
// Field positions
`define PCG_BIT_PHI_DIS   7
`define PCG_BIT_SW_MODE   3
`define PCG_DIV_MSB       2
`define PCG_MULT_MSB      1
`define PCG_BIT_SW_STBY   7
`define PCG_WAIT_MSB      3
`define PCG_BIT_ALL_STOP  0
// Settle wait is (select + 1) << shift system clock ticks
`define PCG_WAIT_SHIFT    5
`endif

// ==== inc/pcg_pkg.sv ====
package pcg_pkg;

    typedef enum logic [1:0] {
        MULT_X1 = 2'h0,
        MULT_X2 = 2'h1,
        MULT_X4 = 2'h2
    } pcg_mult_type;

    typedef enum logic [2:0] {
        DIV_1 = 3'h0,
        DIV_2 = 3'h1,
        DIV_4 = 3'h2
    } pcg_div_type;

    // Gray along run, standby, settle
    typedef enum logic [2:0] {
        MODE_RUN     = 3'h0,
        MODE_SLEEP   = 3'h1,
        MODE_ALLSTOP = 3'h3,
        MODE_STANDBY = 3'h2,
        MODE_SETTLE  = 3'h6,
        MODE_HWSTBY  = 3'h4
    } pcg_mode_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pcg_apb_req_type;

    typedef struct packed {
        logic s1;
        logic s2;
    } pcg_sync_type;

    typedef struct packed {
        logic [7:0]   sys_clk;
        logic [7:0]   pll_ctrl;
        logic [7:0]   stby;
        logic [7:0]   mod_stop;
        logic [7:0]   pwr;
        pcg_mult_type act_mult;
        pcg_div_type  act_div;
        pcg_mode_type mode;
        logic         ext_d;
        logic [7:0]   per_cnt;
        logic [7:0]   period;
        logic [7:0]   sub_cnt;
        logic [1:0]   left;
        logic [1:0]   div_cnt;
        logic [9:0]   wait_cnt;
        logic         phi_tick;
        logic         cpu_en;
        logic [7:0]   periph_en;
        logic         phi_lvl;
        logic [31:0]  prdata;
        logic         pslverr;
    } pcg_state_type;

endpackage : pcg_pkg

// ==== rtl/pcg_sync.sv ====
`timescale 1ns/10ps
module pcg_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    pcg_pkg::pcg_sync_type st_ff;
    pcg_pkg::pcg_sync_type nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d_i;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= {RST_VAL, RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.s2;

endmodule : pcg_sync

// ==== rtl/pcg_top.sv ====
// How it works
// [RL1] PLL multiplies oscillator clock by 1/2/4
// [RL2] Internal clock rises with external rise
// [RL3] Mode 0: new factor waits for standby
// [RL4] Standby wait set by four-bit select
// [RL5] Factor is one after reset
// [RL6] Standby stops generator, applies pending factor
// [RL7] After wake, wait then resume new factor
// [RL8] Mode 1: new factor applies at once
// [RL9] Divider gives half or quarter rate
// [RL10] Software keeps system clock 8-33 MHz
// [RL11] Peripherals clocked from system clock
// [RL12] Wake wait scales with division ratio
// [RL13] Clock writes act despite buffered writes
// [RL14] High-speed mode after reset
// [RL15] Five modes besides high speed: sleep, all-stop, standby, settle, hardware standby
// [RL16] Sleep CPU; division all; stop peripherals
// [RL17] Factor codes 00 x1, 01 x2, 10 x4
// [RL18] Division codes 000, 001, 010 only
// [RL19] Switch mode bit 3, resets 0
// [RL20] Switching never glitches delivered clock
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "pcg_regs.svh"
module pcg_top #(
    parameter int NMOD = 8
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire pcg_pkg::pcg_apb_req_type apb_req_i,
    output logic [31:0]                  prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire logic                    ext_clock_in_pin_i,
    input  wire logic                    sleep_req_i,
    input  wire logic                    wake_irq_i,
    input  wire logic                    hw_standby_n_i,
    output logic                         phi_tick_o,
    output logic                         cpu_clk_en_o,
    output logic [NMOD-1:0]              periph_clk_en_o,
    output logic                         phi_pin_o,
    output logic                         phi_pin_oe_o,
    output logic [2:0]                   power_mode_o,
    output logic [1:0]                   pll_mult_o
);
    pcg_pkg::pcg_state_type st_ff;
    pcg_pkg::pcg_state_type nxt_st;

    logic       rst_q;
    logic       ext_q;
    logic       wake_q;
    logic       hwsb_n_q;
    logic       ext_rise;
    logic       pll_on;
    logic       pll_tick;
    logic       phi_raw;
    logic [7:0] interval;
    logic [1:0] div_mask;
    logic [9:0] wait_tgt;
    logic       wr_acc;
    logic       rd_setup;
    logic [7:0] wbyte;
    logic       run_like;

    pcg_sync #(.RST_VAL(1'b0)) u_rst_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (1'b1),
        .q_o     (rst_q)
    );

    pcg_sync #(.RST_VAL(1'b0)) u_ext_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_q),
        .d_i     (ext_clock_in_pin_i),
        .q_o     (ext_q)
    );

    pcg_sync #(.RST_VAL(1'b0)) u_wake_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_q),
        .d_i     (wake_irq_i),
        .q_o     (wake_q)
    );

    // Idle high so release does not enter hardware standby
    pcg_sync #(.RST_VAL(1'b1)) u_hwsb_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_q),
        .d_i     (hw_standby_n_i),
        .q_o     (hwsb_n_q)
    );

    always_comb begin
        nxt_st   = st_ff;
        wbyte    = apb_req_i.pwdata[7:0];
        wr_acc   = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
        rd_setup = apb_req_i.psel & ~apb_req_i.penable;
        ext_rise = ext_q & ~st_ff.ext_d;
        pll_on   = (st_ff.mode != pcg_pkg::MODE_STANDBY) &&
                   (st_ff.mode != pcg_pkg::MODE_HWSTBY);
        // [RL1] Tick spacing is ext period over factor
        interval = st_ff.period >> st_ff.act_mult;
        if (interval == 8'h00) begin
            interval = 8'h01;
        end
        // [RL9] Divider terminal count per ratio
        case (st_ff.act_div)
            pcg_pkg::DIV_2: div_mask = 2'h1;
            pcg_pkg::DIV_4: div_mask = 2'h3;
            default:        div_mask = 2'h0;
        endcase
        // [RL4] Wait from four-bit select
        wait_tgt = 10'({1'b0, st_ff.stby[`PCG_WAIT_MSB:0]} + 5'h01) << `PCG_WAIT_SHIFT;
        pll_tick = 1'b0;
        nxt_st.ext_d = ext_q;

        // PLL: tick stream locked to external rising edge
        if (st_ff.per_cnt != 8'hff) begin
            nxt_st.per_cnt = st_ff.per_cnt + 8'h01;
        end
        if (!pll_on) begin
            nxt_st.sub_cnt = 8'h00;
            nxt_st.left    = 2'h0;
        end else if (ext_rise) begin
            // [RL2] First tick on the external rise
            pll_tick       = 1'b1;
            nxt_st.period  = st_ff.per_cnt;
            nxt_st.per_cnt = 8'h01;
            nxt_st.sub_cnt = 8'h00;
            nxt_st.left    = 2'((3'h1 << st_ff.act_mult) - 3'h1);
        end else if (st_ff.left != 2'h0 && st_ff.sub_cnt + 8'h01 >= interval) begin
            pll_tick       = 1'b1;
            nxt_st.sub_cnt = 8'h00;
            nxt_st.left    = st_ff.left - 2'h1;
        end else begin
            nxt_st.sub_cnt = st_ff.sub_cnt + 8'h01;
        end

        // Divider
        phi_raw = pll_tick && (st_ff.div_cnt == div_mask);
        if (phi_raw) begin
            nxt_st.div_cnt = 2'h0;
            // [RL20] Ratio switches only at a tick boundary
            // [RL18] Prohibited division codes are ignored
            if (st_ff.sys_clk[`PCG_DIV_MSB:0] <= 3'h2) begin
                nxt_st.act_div = pcg_pkg::pcg_div_type'(st_ff.sys_clk[`PCG_DIV_MSB:0]);
            end
        end else if (pll_tick) begin
            nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
        end

        // APB register writes; no hold-off for pending bus writes
        if (wr_acc) begin
            // [RL13] Clock control takes effect regardless
            if (apb_req_i.paddr == `PCG_OFF_SYS_CLK) begin
                nxt_st.sys_clk = wbyte & `PCG_WM_SYS_CLK;
            end else if (apb_req_i.paddr == `PCG_OFF_PLL_CTRL) begin
                nxt_st.pll_ctrl = wbyte & `PCG_WM_PLL_CTRL;
                // [RL3] [RL8] Mode bit gates immediate use
                // [RL17] Code 11 never becomes active
                if (st_ff.sys_clk[`PCG_BIT_SW_MODE] && wbyte[1:0] != 2'h3) begin
                    nxt_st.act_mult = pcg_pkg::pcg_mult_type'(wbyte[`PCG_MULT_MSB:0]);
                end
            end else if (apb_req_i.paddr == `PCG_OFF_STBY) begin
                nxt_st.stby = wbyte & `PCG_WM_STBY;
            end else if (apb_req_i.paddr == `PCG_OFF_MOD_STOP) begin
                nxt_st.mod_stop = wbyte;
            end else if (apb_req_i.paddr == `PCG_OFF_PWR) begin
                nxt_st.pwr = wbyte & `PCG_WM_PWR;
            end
        end

        // Read data captured in setup so it comes from a flop
        if (rd_setup) begin
            nxt_st.prdata  = 32'h0000_0000;
            nxt_st.pslverr = 1'b0;
            if (apb_req_i.paddr == `PCG_OFF_SYS_CLK) begin
                nxt_st.prdata[7:0] = st_ff.sys_clk;
            end else if (apb_req_i.paddr == `PCG_OFF_PLL_CTRL) begin
                nxt_st.prdata[7:0] = st_ff.pll_ctrl;
            end else if (apb_req_i.paddr == `PCG_OFF_STBY) begin
                nxt_st.prdata[7:0] = st_ff.stby;
            end else if (apb_req_i.paddr == `PCG_OFF_MOD_STOP) begin
                nxt_st.prdata[7:0] = st_ff.mod_stop;
            end else if (apb_req_i.paddr == `PCG_OFF_PWR) begin
                nxt_st.prdata[7:0] = st_ff.pwr;
            end else if (apb_req_i.paddr == `PCG_OFF_STATUS) begin
                nxt_st.prdata[7:0] = {st_ff.mode, st_ff.act_div, st_ff.act_mult};
            end else begin
                nxt_st.pslverr = 1'b1;
            end
        end

        // [RL15] Power mode sequencer
        case (st_ff.mode)
            pcg_pkg::MODE_RUN: begin
                if (sleep_req_i) begin
                    if (st_ff.stby[`PCG_BIT_SW_STBY]) begin
                        // [RL6] Pending factor valid on standby entry
                        nxt_st.mode = pcg_pkg::MODE_STANDBY;
                        if (st_ff.pll_ctrl[1:0] != 2'h3) begin
                            nxt_st.act_mult =
                                pcg_pkg::pcg_mult_type'(st_ff.pll_ctrl[`PCG_MULT_MSB:0]);
                        end
                    end else if (st_ff.pwr[`PCG_BIT_ALL_STOP]) begin
                        nxt_st.mode = pcg_pkg::MODE_ALLSTOP;
                    end else begin
                        nxt_st.mode = pcg_pkg::MODE_SLEEP;
                    end
                end
            end
            pcg_pkg::MODE_SLEEP, pcg_pkg::MODE_ALLSTOP: begin
                if (wake_q) begin
                    nxt_st.mode = pcg_pkg::MODE_RUN;
                end
            end
            pcg_pkg::MODE_STANDBY: begin
                if (wake_q) begin
                    nxt_st.mode     = pcg_pkg::MODE_SETTLE;
                    nxt_st.wait_cnt = 10'h000;
                end
            end
            pcg_pkg::MODE_SETTLE: begin
                // [RL12] Counted in system ticks, so scales with ratio
                // [RL7] Resume once the wait has run out
                if (st_ff.wait_cnt >= wait_tgt) begin
                    nxt_st.mode = pcg_pkg::MODE_RUN;
                end else if (phi_raw) begin
                    nxt_st.wait_cnt = st_ff.wait_cnt + 10'h001;
                end
            end
            default: begin
                if (hwsb_n_q) begin
                    nxt_st.mode     = pcg_pkg::MODE_SETTLE;
                    nxt_st.wait_cnt = 10'h000;
                end
            end
        endcase
        if (!hwsb_n_q) begin
            nxt_st.mode = pcg_pkg::MODE_HWSTBY;
        end

        // Clock enables: one cycle wide, so never a runt
        run_like = (st_ff.mode == pcg_pkg::MODE_RUN) ||
                   (st_ff.mode == pcg_pkg::MODE_SLEEP) ||
                   (st_ff.mode == pcg_pkg::MODE_ALLSTOP);
        nxt_st.phi_tick = phi_raw && run_like;
        // [RL16] Sleep halts the CPU only here; all-stop also stops peripherals
        nxt_st.cpu_en = phi_raw && (st_ff.mode == pcg_pkg::MODE_RUN);
        // [RL11] Peripherals run off the system tick
        nxt_st.periph_en = {8{phi_raw && (st_ff.mode == pcg_pkg::MODE_RUN ||
                              st_ff.mode == pcg_pkg::MODE_SLEEP)}} & ~st_ff.mod_stop;
        if (phi_raw && run_like) begin
            nxt_st.phi_lvl = ~st_ff.phi_lvl;
        end else if (!run_like) begin
            nxt_st.phi_lvl = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_q) begin
        if (!rst_q) begin
            st_ff          <= '0;
            // [RL19] Switch mode bit clear
            st_ff.sys_clk  <= `PCG_RST_SYS_CLK;
            st_ff.pll_ctrl <= `PCG_RST_PLL_CTRL;
            st_ff.stby     <= `PCG_RST_STBY;
            st_ff.mod_stop <= `PCG_RST_MOD_STOP;
            st_ff.pwr      <= `PCG_RST_PWR;
            // [RL5] Factor one
            st_ff.act_mult <= pcg_pkg::MULT_X1;
            st_ff.act_div  <= pcg_pkg::DIV_1;
            // [RL14] High-speed mode
            st_ff.mode     <= pcg_pkg::MODE_RUN;
            st_ff.phi_lvl  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_o        = st_ff.prdata;
    assign pready_o        = 1'b1;
    assign pslverr_o       = st_ff.pslverr & apb_req_i.psel & apb_req_i.penable;
    assign phi_tick_o      = st_ff.phi_tick;
    assign cpu_clk_en_o    = st_ff.cpu_en;
    assign periph_clk_en_o = NMOD'(st_ff.periph_en);
    // Output disable holds the pin high; hardware standby floats it
    assign phi_pin_o       = st_ff.phi_lvl | st_ff.sys_clk[`PCG_BIT_PHI_DIS];
    assign phi_pin_oe_o    = (st_ff.mode != pcg_pkg::MODE_HWSTBY);
    assign power_mode_o    = st_ff.mode;
    assign pll_mult_o      = st_ff.act_mult;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_q);

    a_mult_reset_one: assert property ( // [RL5]
        $rose(rst_q) |-> st_ff.act_mult == pcg_pkg::MULT_X1 &&
                         st_ff.mode == pcg_pkg::MODE_RUN)
        else $error("factor or mode wrong after reset");

    a_deferred_hold: assert property ( // [RL3]
        wr_acc && apb_req_i.paddr == `PCG_OFF_PLL_CTRL &&
        !st_ff.sys_clk[`PCG_BIT_SW_MODE] && st_ff.mode == pcg_pkg::MODE_RUN &&
        !sleep_req_i |=> $stable(st_ff.act_mult))
        else $error("factor changed before standby");

    a_immediate_mult: assert property ( // [RL8]
        wr_acc && apb_req_i.paddr == `PCG_OFF_PLL_CTRL &&
        st_ff.sys_clk[`PCG_BIT_SW_MODE] && apb_req_i.pwdata[1:0] != 2'h3
        |=> st_ff.act_mult == $past(apb_req_i.pwdata[1:0]))
        else $error("factor not applied at once");

    a_standby_apply: assert property ( // [RL6]
        st_ff.mode == pcg_pkg::MODE_RUN && sleep_req_i &&
        st_ff.stby[`PCG_BIT_SW_STBY] && st_ff.pll_ctrl[1:0] != 2'h3 &&
        hwsb_n_q && !wr_acc
        |=> st_ff.act_mult == $past(st_ff.pll_ctrl[1:0]) &&
            st_ff.mode == pcg_pkg::MODE_STANDBY)
        else $error("pending factor not applied in standby");

    a_standby_silent: assert property ( // [RL6]
        st_ff.mode == pcg_pkg::MODE_STANDBY
        |-> !pll_tick ##1 !phi_tick_o && phi_pin_o)
        else $error("clock running in standby");

    a_settle_len: assert property ( // [RL7]
        st_ff.mode == pcg_pkg::MODE_SETTLE && hwsb_n_q
        |=> (st_ff.mode == pcg_pkg::MODE_SETTLE) ==
            ($past(st_ff.wait_cnt) < $past(wait_tgt)))
        else $error("settle ended at wrong count");

    a_settle_gated: assert property ( // [RL7]
        st_ff.mode == pcg_pkg::MODE_SETTLE |=> !cpu_clk_en_o)
        else $error("cpu clocked during settle");

    a_phase_align: assert property ( // [RL2]
        pll_on && ext_rise |-> pll_tick)
        else $error("tick missing on external rise");

    a_quarter_gap: assert property ( // [RL20]
        phi_tick_o && st_ff.act_div == pcg_pkg::DIV_4
        && st_ff.sys_clk[2:0] == 3'h2 |=> !phi_tick_o[*3])
        else $error("quarter rate ticks too close");

    a_sleep_cpu: assert property ( // [RL16]
        st_ff.mode == pcg_pkg::MODE_SLEEP |=> !cpu_clk_en_o)
        else $error("cpu clocked in sleep");

    c_standby_cycle: cover property (
        st_ff.mode == pcg_pkg::MODE_SETTLE ##1 st_ff.mode == pcg_pkg::MODE_RUN);
    c_immediate: cover property (
        wr_acc && apb_req_i.paddr == `PCG_OFF_PLL_CTRL && st_ff.sys_clk[3]);
    c_sleep_wake: cover property (
        st_ff.mode == pcg_pkg::MODE_SLEEP ##1 st_ff.mode == pcg_pkg::MODE_RUN);
    c_quarter: cover property (phi_tick_o && st_ff.act_div == pcg_pkg::DIV_4);

endmodule : pcg_top

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    typedef struct {
        string       nm;
        logic [31:0] exp;
        int          tol;
    } pcg_tb_exp_type;

    logic                     mclk_i    = 1'b0;
    logic                     rst_n_i   = 1'b0;
    pcg_pkg::pcg_apb_req_type req       = '0;
    logic                     ext       = 1'b0;
    logic                     sleep_req = 1'b0;
    logic                     wake      = 1'b0;
    logic                     hw_n      = 1'b1;
    logic [31:0]              prdata_o;
    logic                     pready_o;
    logic                     pslverr_o;
    logic                     phi_tick_o;
    logic                     cpu_clk_en_o;
    logic [7:0]               per_en;
    logic                     phi_pin_o;
    logic                     phi_pin_oe_o;
    logic [2:0]               power_mode_o;
    logic [1:0]               pll_mult_o;
    pcg_tb_exp_type           rd_q[$];
    pcg_tb_exp_type           chk_q[$];
    logic [31:0]              got_q[$];
    event                     chk_ev;
    int                       n_fail, cmp_count, cyc, n_phi, n_cpu, n_p0, n_p1, i, n;
    int                       ph, cp, p0, p1;
    logic [31:0]              seed      = 32'h370aadf1;

    pcg_top #(.NMOD(8)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clock_in_pin_i(ext),
        .sleep_req_i(sleep_req), .wake_irq_i(wake), .hw_standby_n_i(hw_n),
        .phi_tick_o(phi_tick_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(per_en),
        .phi_pin_o(phi_pin_o), .phi_pin_oe_o(phi_pin_oe_o), .power_mode_o(power_mode_o),
        .pll_mult_o(pll_mult_o)
    );

    always #12.5 mclk_i = ~mclk_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic cmp(input pcg_tb_exp_type e, input logic [31:0] got);
        int d;
        d = (got > e.exp) ? int'(got - e.exp) : int'(e.exp - got);
        cmp_count++;
        if ((e.tol == 0) ? (got !== e.exp) : ($isunknown(got) || d > e.tol)) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", e.nm, e.exp, got);
        end
    endtask : cmp

    // Oscillator at a tenth of mclk, counters, hang guard
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc % 5 == 0) ext <= ~ext; // scaled legal range
        if (phi_tick_o === 1'b1) n_phi++;
        if (cpu_clk_en_o === 1'b1) n_cpu++;
        if (per_en[0] === 1'b1) n_p0++;
        if (per_en[1] === 1'b1) n_p1++;
        if (cyc > 30000) begin
            n_fail++;
            end_sim();
        end
    end

    // Completed APB transfers take the oldest notes
    always @(posedge mclk_i) begin
        if (req.psel && req.penable && pready_o === 1'b1 && rd_q.size() > 0) begin
            if (!req.pwrite) cmp(rd_q.pop_front(), prdata_o);
            cmp(rd_q.pop_front(), {31'h0, pslverr_o});
        end
    end

    always @(chk_ev) begin
        while (chk_q.size() > 0) cmp(chk_q.pop_front(), got_q.pop_front());
    end

    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got,
                         input int tol);
        chk_q.push_back('{nm, ex, tol});
        got_q.push_back(got);
        ->chk_ev;
    endtask : check

    // Request held until pready seen high at an access edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic err);
        if (!wr) rd_q.push_back('{"prdata", ex, 0});
        rd_q.push_back('{"pslverr", {31'h0, err}, 0});
        @(posedge mclk_i);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        apb(1'b0, a, 32'h0, {24'h0, ex}, 1'b0);
    endtask : rd

    task automatic wait_mode(input logic [2:0] m, input int lim, output int k);
        k = 0;
        while (power_mode_o !== m && k < lim) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        check("power_mode", {29'h0, m}, {29'h0, power_mode_o}, 0);
    endtask : wait_mode

    task automatic measure;
        int a, b, c, d;
        repeat (60) @(posedge mclk_i);
        #1;
        a = n_phi;
        b = n_cpu;
        c = n_p0;
        d = n_p1;
        repeat (400) @(posedge mclk_i);
        #1;
        ph = n_phi - a;
        cp = n_cpu - b;
        p0 = n_p0 - c;
        p1 = n_p1 - d;
    endtask : measure

    task automatic sleep_pulse;
        @(posedge mclk_i);
        sleep_req <= 1'b1;
        @(posedge mclk_i);
        sleep_req <= 1'b0;
    endtask : sleep_pulse

    // Deferred factor change through standby, settle select 1
    task automatic stby_cycle(input logic [2:0] dv, input logic [1:0] m, input logic [1:0] old);
        int k, ex;
        wr(8'h00, {5'h0, dv});
        wr(8'h04, {6'h0, m});
        check("pll_mult", {30'h0, old}, {30'h0, pll_mult_o}, 0);
        wr(8'h08, 8'hc1);
        sleep_pulse();
        wait_mode(3'h2, 5, k);
        check("pll_mult", {30'h0, m}, {30'h0, pll_mult_o}, 0);
        check("phi_pin", 32'h1, {31'h0, phi_pin_o}, 0);
        @(posedge mclk_i) wake <= 1'b1;
        wait_mode(3'h6, 8, k);
        @(posedge mclk_i) wake <= 1'b0;
        wait_mode(3'h0, 5000, k);
        ex = 640 * (1 << dv) / (1 << m);
        check("settle_cycles", 32'(ex), 32'(k), ex / 16 + 20);
        check("pll_mult", {30'h0, m}, {30'h0, pll_mult_o}, 0);
        wr(8'h08, 8'h41);
    endtask : stby_cycle

    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        check("pll_mult", 32'h0, {30'h0, pll_mult_o}, 0);
        check("power_mode", 32'h0, {29'h0, power_mode_o}, 0);
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h40);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'hff, 32'h0, 1'b1);
        for (i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            wr(8'h04, seed[7:0]);
            rd(8'h04, seed[7:0] & 8'h0b);
        end
        #1;
        check("pll_mult", 32'h0, {30'h0, pll_mult_o}, 0);
        wr(8'h00, 8'h08);
        rd(8'h00, 8'h08);
        // Immediate factor switching, code 3 keeps the last
        for (i = 0; i < 4; i++) begin
            wr(8'h04, i[7:0]);
            @(posedge mclk_i);
            #1;
            check("pll_mult", (i == 3) ? 32'h2 : 32'(i), {30'h0, pll_mult_o}, 0);
            measure();
            check("ticks", 32'(40 << ((i == 3) ? 2 : i)), 32'(ph), 3);
            check("cpu_ticks", 32'(ph), 32'(cp), 0);
            check("per_ticks", 32'(ph), 32'(p0), 0);
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h00, 8'h08 | i[7:0]);
            measure();
            check("ticks", 32'(160 >> ((i == 3) ? 2 : i)), 32'(ph), 3);
            rd(8'h14, {3'h0, (i == 3) ? 3'h2 : i[2:0], 2'h2});
        end
        seed = lfsr_next(seed);
        wr(8'h0c, seed[7:0]);
        rd(8'h0c, seed[7:0]);
        wr(8'h0c, 8'h02);
        measure();
        check("per1_ticks", 32'h0, 32'(p1), 0);
        check("per0_ticks", 32'(ph), 32'(p0), 0);
        sleep_pulse();
        wait_mode(3'h1, 5, n);
        measure();
        check("cpu_ticks", 32'h0, 32'(cp), 0);
        check("per0_ticks", 32'(ph), 32'(p0), 0);
        @(posedge mclk_i) wake <= 1'b1;
        wait_mode(3'h0, 8, n);
        @(posedge mclk_i) wake <= 1'b0;
        wr(8'h10, 8'h01);
        sleep_pulse();
        wait_mode(3'h3, 5, n);
        measure();
        check("ticks", 32'd40, 32'(ph), 3);
        check("per0_ticks", 32'h0, 32'(p0 + cp), 0);
        @(posedge mclk_i) wake <= 1'b1;
        wait_mode(3'h0, 8, n);
        @(posedge mclk_i) wake <= 1'b0;
        wr(8'h10, 8'h00);
        wr(8'h0c, 8'h00);
        stby_cycle(3'h1, 2'h1, 2'h2);
        stby_cycle(3'h2, 2'h0, 2'h1);
        hw_n <= 1'b0;
        wait_mode(3'h4, 8, n);
        check("phi_oe", 32'h0, {31'h0, phi_pin_oe_o}, 0);
        @(posedge mclk_i) hw_n <= 1'b1;
        wait_mode(3'h6, 8, n);
        wait_mode(3'h0, 5000, n);
        repeat (4) @(posedge mclk_i);
        end_sim();
    end
endmodule : tb_top
